// ==== clock_ctl_pkg.sv ====
/*
 * Constants shared by the clock mode and output routing control logic:
 * register indices, field positions, encodings, reset values and timing.
 * Assumes a single 100 MHz core clock and no other clock domain.
 */
package clock_ctl_pkg;
	localparam int CLK_PERIOD_NS = 10;
	// activity watchdog on reference and input clock samples
	localparam int ACT_TIMEOUT_NS = 20000;
	localparam int ACT_TIMEOUT_CYC = ACT_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int ACT_CNT_W = $clog2(ACT_TIMEOUT_CYC + 1);
	localparam int BOOT_CYC = 4;
	localparam int INIT_TOGGLES = 3;
	localparam int RATIO_W = 32;
	localparam int FRACN_W = 48;

	// register indices on the plain register port
	localparam logic [3:0] REG_GLOBAL = 4'h0;
	localparam logic [3:0] REG_MODAL = 4'h1;
	localparam logic [3:0] REG_RATIO0 = 4'h2;
	localparam logic [3:0] REG_RATIO3 = 4'h5;
	localparam logic [3:0] REG_STATUS = 4'h6;
	localparam logic [31:0] GLOBAL_RST = 32'h0000_0000;
	localparam logic [15:0] MODAL_RST = 16'h0000;
	localparam logic [31:0] RATIO_RST = 32'h0010_0000;

	// global register fields
	localparam int G_LOCK_STYLE = 0;
	localparam int G_KEEP_CLK = 1;
	localparam int G_FORMAT = 2;
	localparam int G_DIV_LO = 3;
	localparam int G_FUNC_LO = 5;
	// modal set: 4 bits per mode, shift select low, aux source high
	localparam int MODAL_SET_W = 4;
	localparam int MODAL_SRC_LO = 2;

	// aux source codes
	localparam logic [1:0] AUX_REF = 2'h0;
	localparam logic [1:0] AUX_INPUT = 2'h1;
	localparam logic [1:0] AUX_PLL = 2'h2;
	localparam logic [1:0] AUX_LOCK = 2'h3;
	// special pin function codes
	localparam logic [2:0] FN_DIS_MAIN = 3'h0;
	localparam logic [2:0] FN_DIS_AUX = 3'h1;
	localparam logic [2:0] FN_DIS_BOTH = 3'h2;
	localparam logic [2:0] FN_RMOD = 3'h3;
	localparam logic [2:0] FN_RSV_LAST = 3'h6;
	localparam logic [2:0] FN_FORCE_PLL = 3'h7;
	// reference divider codes
	localparam logic [1:0] DIV_BY4 = 2'h0;
	localparam logic [1:0] DIV_BY2 = 2'h1;
	// ratio format
	localparam logic FMT_HIGH_MULT = 1'b0;
	localparam int FMT_PAD = 8;
endpackage : clock_ctl_pkg

// ==== pin_sync.sv ====
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes inputs are asynchronous to core_clk; output is a registered level.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int W = 1
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] level
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} sync_type;

	sync_type st_r;
	sync_type st_nxt;

	// a bit moves only when stages two and three agree
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.s1 = pin;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.q = (st_r.s2 & st_r.s3) | (st_r.q & (st_r.s2 ^ st_r.s3));
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign level = st_r.q;
endmodule : pin_sync
`default_nettype wire

// ==== clean_gate.sv ====
/*
 * Glitch-free gate for a sampled clock level.
 * Assumes clk_lvl is already synchronised to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module clean_gate (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_lvl,
	input wire logic enable,
	output logic gated,
	output logic en_state
);
	typedef struct packed {
		logic en;
		logic out;
	} gate_type;

	gate_type st_r;
	gate_type st_nxt;

	// enable moves only in the low phase, so no period is cut short
	always_comb
	begin
		st_nxt = st_r;
		if (!clk_lvl)
			st_nxt.en = enable;
		st_nxt.out = clk_lvl & st_r.en;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign gated = st_r.out;
	assign en_state = st_r.en;

	property p_en_low_only;
		@(posedge core_clk) disable iff (rst)
		$changed(st_r.en) |-> !$past(clk_lvl);
	endproperty
	a_en_low_only: assert property (p_en_low_only) else $error("gate enable moved in high phase");
endmodule : clean_gate
`default_nettype wire

// ==== clock_mode_output_control.sv ====
/*
 * Mode pin decode, ratio selection and output routing of the clock multiplier.
 * Assumes the PLL core supplies a lock level, and that reference, input and
 * PLL clocks arrive as pins sampled on core_clk (well below its rate).
 */
`timescale 1ns/1ps
`default_nettype none
module clock_mode_output_control (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic mode_select_low_pin,
	input wire logic mode_select_high_pin,
	input wire logic special_function_pin,
	input wire logic timing_reference_source,
	input wire logic freq_reference_input,
	input wire logic pll_clock,
	input wire logic pll_locked,
	input wire logic field_programmed,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic main_clk_out,
	output logic main_clk_oe,
	output logic aux_out,
	output logic aux_oe,
	output logic [31:0] effective_ratio,
	output logic [47:0] fracn_value,
	output logic relock_req
);
	localparam int NSYNC = 7;
	localparam int NACT = 2;

	typedef enum logic [1:0] {BOOT, WAIT_TOGGLES, RUN} init_type;

	typedef struct packed {
		logic [31:0] glob;
		logic [15:0] modal;
		logic [3:0][31:0] ratio;
		logic [31:0] rdata;
		init_type init;
		logic [2:0] boot_cnt;
		logic fprog;
		logic [1:0] toggles;
		logic [1:0] mode_prev;
		logic m2_prev;
		logic [1:0] act_src;
		logic lock_seen;
		logic [NACT-1:0][clock_ctl_pkg::ACT_CNT_W-1:0] act_cnt;
		logic [NACT-1:0] act_prev;
		logic [NACT-1:0] present;
		logic [31:0] eff;
		logic [47:0] fracn;
		logic relock;
		logic main_out;
		logic main_oe;
		logic aux_out;
		logic aux_oe;
	} state_type;

	state_type st_r;
	state_type st_nxt;

	logic [NSYNC-1:0] sync_lvl;
	logic [1:0] q_mode;
	logic q_m2;
	logic q_ref;
	logic q_in;
	logic q_pll;
	logic q_strap;
	logic main_gated;
	logic main_gate_en;
	logic aux_gated;
	logic aux_gate_en;
	logic aux_lvl;
	logic [2:0] fn;
	logic [1:0] src_want;
	logic [1:0] shift_sel;
	logic main_dis;
	logic aux_dis;
	logic rmod_on;
	logic main_want;
	logic init_ok;

	// every pin, clocks included, enters through the agreement synchroniser
	pin_sync #(.W(NSYNC)) u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.pin({field_programmed, pll_clock, freq_reference_input, timing_reference_source,
			special_function_pin, mode_select_high_pin, mode_select_low_pin}),
		.level(sync_lvl)
	);
	assign q_mode = sync_lvl[1:0];
	assign q_m2 = sync_lvl[2];
	assign q_ref = sync_lvl[3];
	assign q_in = sync_lvl[4];
	assign q_pll = sync_lvl[5];
	assign q_strap = sync_lvl[6];

	// right shift by one to four places when the modifier is on
	function automatic logic [31:0] apply_rmod(input logic [31:0] r, input logic on, input logic [1:0] sel);
		logic [2:0] sh;
		sh = {1'b0, sel} + 3'h1;
		return on ? (r >> sh) : r;
	endfunction : apply_rmod

	// normalise to 28.20 and undo the reference divider
	function automatic logic [47:0] to_fracn(input logic [31:0] r, input logic fmt, input logic [1:0] div);
		logic [47:0] n;
		n = (fmt == clock_ctl_pkg::FMT_HIGH_MULT) ? {8'h00, r, 8'h00} : {16'h0000, r};
		if (div == clock_ctl_pkg::DIV_BY4)
			n = n << 2;
		else if (div == clock_ctl_pkg::DIV_BY2)
			n = n << 1;
		return n;
	endfunction : to_fracn

	// level of an aux source code, lock code carries no clock
	function automatic logic src_level(input logic [1:0] s, input logic r, input logic i, input logic p);
		case (s)
			clock_ctl_pkg::AUX_REF: return r;
			clock_ctl_pkg::AUX_INPUT: return i;
			clock_ctl_pkg::AUX_PLL: return p;
			default: return 1'b0;
		endcase
	endfunction : src_level

	// global function field shared by all four modes; shift select taken per mode from the modal set
	assign fn = st_r.glob[clock_ctl_pkg::G_FUNC_LO +: 3];
	assign shift_sel = st_r.modal[q_mode * clock_ctl_pkg::MODAL_SET_W +: 2];
	assign main_dis = q_m2 && (fn == clock_ctl_pkg::FN_DIS_MAIN || fn == clock_ctl_pkg::FN_DIS_BOTH);
	assign aux_dis = q_m2 && (fn == clock_ctl_pkg::FN_DIS_AUX || fn == clock_ctl_pkg::FN_DIS_BOTH);
	assign rmod_on = q_m2 && (fn == clock_ctl_pkg::FN_RMOD);
	assign init_ok = (st_r.init == RUN);
	assign main_want = init_ok && !main_dis && (pll_locked || st_r.glob[clock_ctl_pkg::G_KEEP_CLK]);
	assign aux_lvl = src_level(st_r.act_src, q_ref, q_in, q_pll);

	// override to pll clock when the pin is high under function 111
	always_comb
	begin
		if (q_m2 && fn == clock_ctl_pkg::FN_FORCE_PLL)
			src_want = clock_ctl_pkg::AUX_PLL;
		else
			src_want = st_r.modal[q_mode * clock_ctl_pkg::MODAL_SET_W + clock_ctl_pkg::MODAL_SRC_LO +: 2];
	end

	clean_gate u_main_gate (
		.core_clk(core_clk),
		.rst(rst),
		.clk_lvl(q_pll),
		.enable(main_want),
		.gated(main_gated),
		.en_state(main_gate_en)
	);

	clean_gate u_aux_gate (
		.core_clk(core_clk),
		.rst(rst),
		.clk_lvl(aux_lvl),
		.enable(init_ok && !aux_dis),
		.gated(aux_gated),
		.en_state(aux_gate_en)
	);

	// next state of the whole block
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rdata = '0;
		st_nxt.relock = 1'b0;
		st_nxt.mode_prev = q_mode;
		st_nxt.m2_prev = q_m2;

		// register port; unmapped reads return zero
		if (reg_wr)
		begin
			if (reg_addr == clock_ctl_pkg::REG_GLOBAL)
				st_nxt.glob = reg_wdata;
			else if (reg_addr == clock_ctl_pkg::REG_MODAL)
				st_nxt.modal = reg_wdata[15:0];
			else if (reg_addr >= clock_ctl_pkg::REG_RATIO0 && reg_addr <= clock_ctl_pkg::REG_RATIO3)
				st_nxt.ratio[2'(reg_addr - clock_ctl_pkg::REG_RATIO0)] = reg_wdata;
		end
		if (reg_rd)
		begin
			if (reg_addr == clock_ctl_pkg::REG_GLOBAL)
				st_nxt.rdata = st_r.glob;
			else if (reg_addr == clock_ctl_pkg::REG_MODAL)
				st_nxt.rdata = {16'h0000, st_r.modal};
			else if (reg_addr >= clock_ctl_pkg::REG_RATIO0 && reg_addr <= clock_ctl_pkg::REG_RATIO3)
				st_nxt.rdata = st_r.ratio[2'(reg_addr - clock_ctl_pkg::REG_RATIO0)];
			else if (reg_addr == clock_ctl_pkg::REG_STATUS)
				st_nxt.rdata = {22'h000000, st_r.act_src, aux_gate_en, main_gate_en, q_mode,
					init_ok, st_r.present, st_r.lock_seen};
		end

		// strap caught once the synchroniser has filled
		case (st_r.init)
			BOOT:
			begin
				st_nxt.boot_cnt = st_r.boot_cnt + 3'h1;
				if (st_r.boot_cnt == 3'(clock_ctl_pkg::BOOT_CYC))
				begin
					st_nxt.fprog = q_strap;
					st_nxt.init = q_strap ? WAIT_TOGGLES : RUN;
				end
			end
			WAIT_TOGGLES:
			begin
				if (q_mode != st_r.mode_prev)
					st_nxt.toggles = st_r.toggles + 2'h1;
				if (st_nxt.toggles == 2'(clock_ctl_pkg::INIT_TOGGLES))
					st_nxt.init = RUN;
			end
			RUN: st_nxt.init = RUN;
			default: st_nxt.init = BOOT;
		endcase

		// activity watchdogs on reference and input clock samples
		for (int k = 0; k < NACT; k++)
		begin
			st_nxt.act_prev[k] = (k == 0) ? q_ref : q_in;
			if (st_nxt.act_prev[k] != st_r.act_prev[k])
				st_nxt.act_cnt[k] = '0;
			else if (st_r.act_cnt[k] != clock_ctl_pkg::ACT_CNT_W'(clock_ctl_pkg::ACT_TIMEOUT_CYC))
				st_nxt.act_cnt[k] = st_r.act_cnt[k] + 1'b1;
			st_nxt.present[k] = (st_nxt.act_cnt[k] != clock_ctl_pkg::ACT_CNT_W'(clock_ctl_pkg::ACT_TIMEOUT_CYC));
		end

		// restart lock on mode change, ratio-affecting pin change or lost clock
		if (st_r.init != BOOT && q_mode != st_r.mode_prev)
			st_nxt.relock = 1'b1;
		if (q_m2 != st_r.m2_prev && fn >= clock_ctl_pkg::FN_RMOD && fn <= clock_ctl_pkg::FN_RSV_LAST)
			st_nxt.relock = 1'b1;
		if ((st_r.present & ~st_nxt.present) != '0)
			st_nxt.relock = 1'b1;

		// lock view only refreshed while the reference is alive
		if (st_r.present[0])
			st_nxt.lock_seen = pll_locked;

		// ratio path
		st_nxt.eff = apply_rmod(st_r.ratio[q_mode], rmod_on, shift_sel);
		st_nxt.fracn = to_fracn(st_r.eff, st_r.glob[clock_ctl_pkg::G_FORMAT],
			st_r.glob[clock_ctl_pkg::G_DIV_LO +: 2]);

		// source switch: between ref and pll only in a common low phase
		if (src_want != st_r.act_src)
		begin
			if ((src_want == clock_ctl_pkg::AUX_REF || src_want == clock_ctl_pkg::AUX_PLL) &&
				(st_r.act_src == clock_ctl_pkg::AUX_REF || st_r.act_src == clock_ctl_pkg::AUX_PLL))
			begin
				if (!q_ref && !q_pll)
					st_nxt.act_src = src_want;
			end
			else
				st_nxt.act_src = src_want;
		end

		// main pin: gated clock, tri-stated by the special pin
		st_nxt.main_out = main_gated;
		st_nxt.main_oe = !main_dis;

		// aux pin: gated clock or unlock indicator per lock pin style
		if (st_r.act_src == clock_ctl_pkg::AUX_LOCK)
		begin
			if (!st_r.glob[clock_ctl_pkg::G_LOCK_STYLE])
			begin
				st_nxt.aux_out = !st_r.lock_seen;
				st_nxt.aux_oe = !aux_dis;
			end
			else
			begin
				st_nxt.aux_out = 1'b0;
				st_nxt.aux_oe = !aux_dis && !st_r.lock_seen;
			end
		end
		else
		begin
			st_nxt.aux_out = aux_gated;
			st_nxt.aux_oe = !aux_dis;
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			st_r <= '0;
			st_r.glob <= clock_ctl_pkg::GLOBAL_RST;
			st_r.modal <= clock_ctl_pkg::MODAL_RST;
			st_r.ratio <= {4{clock_ctl_pkg::RATIO_RST}};
			st_r.init <= BOOT;
		end
		else
			st_r <= st_nxt;
	end

	assign reg_rdata = st_r.rdata;
	assign main_clk_out = st_r.main_out;
	assign main_clk_oe = st_r.main_oe;
	assign aux_out = st_r.aux_out;
	assign aux_oe = st_r.aux_oe;
	assign effective_ratio = st_r.eff;
	assign fracn_value = st_r.fracn;
	assign relock_req = st_r.relock;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	property p_main_hiz;
		(q_m2 && (fn == clock_ctl_pkg::FN_DIS_MAIN || fn == clock_ctl_pkg::FN_DIS_BOTH)) |=> !main_clk_oe;
	endproperty
	a_main_hiz: assert property (p_main_hiz) else $error("main pin not tri-stated");

	property p_aux_hiz;
		(q_m2 && (fn == clock_ctl_pkg::FN_DIS_AUX || fn == clock_ctl_pkg::FN_DIS_BOTH)) |=> !aux_oe;
	endproperty
	a_aux_hiz: assert property (p_aux_hiz) else $error("aux pin not tri-stated");

	property p_no_shift;
		(fn != clock_ctl_pkg::FN_RMOD || !q_m2) |=> effective_ratio == $past(st_r.ratio[q_mode]);
	endproperty
	a_no_shift: assert property (p_no_shift) else $error("ratio shifted without enable");

	property p_force_pll;
		(q_m2 && fn == clock_ctl_pkg::FN_FORCE_PLL && !q_ref && !q_pll) |=>
			st_r.act_src == clock_ctl_pkg::AUX_PLL;
	endproperty
	a_force_pll: assert property (p_force_pll) else $error("aux source not forced to pll");

	property p_mode_relock;
		(st_r.init == RUN && $changed(q_mode)) |=> relock_req;
	endproperty
	a_mode_relock: assert property (p_mode_relock) else $error("mode change without relock");

	property p_unlock_low;
		(!main_gate_en) |=> !main_clk_out;
	endproperty
	a_unlock_low: assert property (p_unlock_low) else $error("main clock toggles while gated");

	property p_od_style;
		(st_r.act_src == clock_ctl_pkg::AUX_LOCK && st_r.glob[clock_ctl_pkg::G_LOCK_STYLE]) |=> !aux_out;
	endproperty
	a_od_style: assert property (p_od_style) else $error("open-drain lock pin driven high");

	property p_lock_hold;
		(!st_r.present[0]) |=> $stable(st_r.lock_seen);
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("lock view moved without reference");

	property p_init_hold;
		(st_r.init == WAIT_TOGGLES) |-> ##2 !main_clk_out;
	endproperty
	a_init_hold: assert property (p_init_hold) else $error("clock out before init toggles");
endmodule : clock_mode_output_control
`default_nettype wire

// ==== board_clock_model.sv ====
/*
 * Board-side model: makes the timing reference, input clock and pll clock
 * as slow square waves sampled by the block.
 * Assumes core_clk is the block clock; run bits stop each wave low.
 */
`timescale 1ns/1ps
`default_nettype none
module board_clock_model #(
	parameter int HALF = 4
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [2:0] run,
	output logic ref_wave,
	output logic input_wave,
	output logic pll_wave
);
	logic [7:0] cnt_r;
	logic [2:0] wave_r;
	// waves held static low through reset, started only afterwards
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_r <= 8'h00;
			wave_r <= 3'h0;
		end
		else if (cnt_r == 8'(HALF - 1))
		begin
			cnt_r <= 8'h00;
			wave_r <= (~wave_r) & run;
		end
		else
		begin
			cnt_r <= cnt_r + 8'h01;
			wave_r <= wave_r & run; // stopped wave parks low, no toggling
		end
	end
	assign {pll_wave, input_wave, ref_wave} = wave_r;
endmodule : board_clock_model
`default_nettype wire

// ==== clock_mode_output_control_bench.sv ====
/*
 * Self-checking bench for the clock mode and output routing block.
 * Assumes the board model supplies the sampled clocks; factory part strap until the field part reset test.
 */
`timescale 1ns/1ps
`default_nettype none
module clock_mode_output_control_bench;
	logic core_clk, rst, m_lo, m_hi, sp, locked;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, eff;
	logic reg_wr, reg_rd, ref_w, in_w, pll_w, strap;
	logic [47:0] fracn;
	logic main_clk_out, main_clk_oe, aux_out, aux_oe, relock_req;
	logic [2:0] run;
	int mismatches, num_checks;
	board_clock_model #(.HALF(4)) brd (.core_clk(core_clk), .rst(rst), .run(run),
		.ref_wave(ref_w), .input_wave(in_w), .pll_wave(pll_w));
	clock_mode_output_control uut (.core_clk(core_clk), .rst(rst), .mode_select_low_pin(m_lo),
		.mode_select_high_pin(m_hi), .special_function_pin(sp), .timing_reference_source(ref_w),
		.freq_reference_input(in_w), .pll_clock(pll_w), .pll_locked(locked), .field_programmed(strap),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .main_clk_out(main_clk_out), .main_clk_oe(main_clk_oe),
		.aux_out(aux_out), .aux_oe(aux_oe), .effective_ratio(eff), .fracn_value(fracn), .relock_req(relock_req));
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t word %h expected %h", $time, got, exp);
		end
	endtask : chk32
	task automatic chk48(input logic [47:0] got, input logic [47:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t fraction %h expected %h", $time, got, exp);
		end
	endtask : chk48
	task automatic chk1(input logic got, input logic exp);
		num_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t level %b expected %b", $time, got, exp);
		end
	endtask : chk1
	task automatic chkn(input int got, input int lo, input int hi);
		num_checks++;
		if (got < lo || got > hi)
		begin
			mismatches++;
			$display("[ERR] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask : chkn
	// one-cycle strobes; next access waits an edge, so no double drive
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata; // data stands in this cycle only
	endtask : rd
	task automatic pins(input int m, input logic s);
		@(posedge core_clk);
		m_lo <= m[0];
		m_hi <= m[1];
		sp <= s;
	endtask : pins
	// counts output edges and relock pulses over n settled cycles
	task automatic watch(input int n, output int tm, output int ta, output int rl);
		logic pm, pa;
		tm = 0;
		ta = 0;
		rl = 0;
		pm = main_clk_out;
		pa = aux_out;
		repeat (n)
		begin
			@(posedge core_clk);
			#1;
			if (main_clk_out !== pm) tm++;
			if (aux_out !== pa) ta++;
			if (relock_req === 1'b1) rl++;
			pm = main_clk_out;
			pa = aux_out;
		end
	endtask : watch
	function automatic logic [31:0] gcfg(input logic s, input logic k, input logic [2:0] f);
		gcfg = 32'h0000_0000;
		gcfg[clock_ctl_pkg::G_LOCK_STYLE] = s;
		gcfg[clock_ctl_pkg::G_KEEP_CLK] = k;
		gcfg[clock_ctl_pkg::G_FUNC_LO +: 3] = f;
	endfunction : gcfg
	function automatic logic [31:0] rat(input int m);
		rat = {4'(m + 1), 28'h3C5_A6F0};
	endfunction : rat
	task automatic t_reset_values();
		logic [31:0] d;
		rd(clock_ctl_pkg::REG_GLOBAL, d);
		chk32(d, clock_ctl_pkg::GLOBAL_RST);
		rd(clock_ctl_pkg::REG_MODAL, d);
		chk32(d, 32'(clock_ctl_pkg::MODAL_RST));
		for (int i = 2; i < 6; i++)
		begin
			rd(4'(i), d);
			chk32(d, clock_ctl_pkg::RATIO_RST);
		end
		rd(4'hF, d);
		chk32(d, 32'h0000_0000); // unmapped place reads zero
	endtask : t_reset_values
	task automatic t_ratio();
		logic [31:0] d;
		int tm, ta, rl;
		wr(clock_ctl_pkg::REG_GLOBAL, gcfg(1'b0, 1'b0, clock_ctl_pkg::FN_RMOD));
		wr(clock_ctl_pkg::REG_MODAL, 32'h0000_3210); // mode m shift code m
		for (int m = 0; m < 4; m++) wr(clock_ctl_pkg::REG_RATIO0 + 4'(m), rat(m));
		for (int m = 0; m < 4; m++)
		begin
			pins(m, 1'b0);
			watch(10, tm, ta, rl);
			if (m > 0) chkn(rl, 1, 1);
			chk32(eff, rat(m));
			rd(clock_ctl_pkg::REG_STATUS, d);
			chk32({30'h0, d[5:4]}, 32'(m));
			pins(m, 1'b1);
			watch(10, tm, ta, rl);
			chkn(rl, 1, 1);
			chk32(eff, rat(m) >> (m + 1));
			pins(m, 1'b0);
			watch(10, tm, ta, rl);
		end
	endtask : t_ratio
	task automatic t_disable();
		int tm, ta, rl;
		wr(clock_ctl_pkg::REG_MODAL, 32'h0000_0000);
		for (int f = 0; f < 3; f++)
		begin
			wr(clock_ctl_pkg::REG_GLOBAL, gcfg(1'b0, 1'b0, 3'(f)));
			pins(0, 1'b1);
			watch(10, tm, ta, rl);
			chk1(main_clk_oe, !(f == 0 || f == 2));
			chk1(aux_oe, !(f == 1 || f == 2));
			pins(0, 1'b0);
			watch(10, tm, ta, rl);
			chk1(main_clk_oe, 1'b1);
			chk1(aux_oe, 1'b1);
		end
	endtask : t_disable
	task automatic t_gate();
		int tm, ta, rl;
		wr(clock_ctl_pkg::REG_GLOBAL, gcfg(1'b0, 1'b0, clock_ctl_pkg::FN_RMOD));
		watch(64, tm, ta, rl);
		chkn(tm, 8, 64);
		@(posedge core_clk);
		locked <= 1'b0;
		watch(8, tm, ta, rl);
		watch(64, tm, ta, rl);
		chkn(tm, 0, 0);
		chk1(main_clk_out, 1'b0);
		wr(clock_ctl_pkg::REG_GLOBAL, gcfg(1'b0, 1'b1, clock_ctl_pkg::FN_RMOD));
		watch(64, tm, ta, rl);
		chkn(tm, 8, 64);
		wr(clock_ctl_pkg::REG_GLOBAL, gcfg(1'b0, 1'b0, clock_ctl_pkg::FN_RMOD));
		locked <= 1'b1;
	endtask : t_gate
	// only the selected source may reach the aux pin
	task automatic t_aux();
		int tm, ta, rl;
		for (int c = 0; c < 3; c++)
		begin
			wr(clock_ctl_pkg::REG_MODAL, 32'(c) << clock_ctl_pkg::MODAL_SRC_LO);
			run <= 3'(1 << c);
			watch(8, tm, ta, rl);
			watch(64, tm, ta, rl);
			chkn(ta, 8, 64);
			@(posedge core_clk);
			run <= 3'(~(1 << c));
			watch(8, tm, ta, rl);
			watch(64, tm, ta, rl);
			chkn(ta, 0, 0);
		end
		wr(clock_ctl_pkg::REG_MODAL, 32'h0000_0000);
		wr(clock_ctl_pkg::REG_GLOBAL, gcfg(1'b0, 1'b0, clock_ctl_pkg::FN_FORCE_PLL));
		run <= 3'b100;
		pins(0, 1'b1);
		watch(8, tm, ta, rl);
		watch(64, tm, ta, rl);
		chkn(ta, 8, 64);
		pins(0, 1'b0);
		// switch back waits for a common low phase, so settle longer
		watch(16, tm, ta, rl);
		watch(64, tm, ta, rl);
		chkn(ta, 0, 0);
		@(posedge core_clk);
		run <= 3'b111;
	endtask : t_aux
	task automatic t_lock();
		int tm, ta, rl;
		wr(clock_ctl_pkg::REG_MODAL, 32'h0000_000C);
		for (int s = 0; s < 2; s++)
		begin
			wr(clock_ctl_pkg::REG_GLOBAL, gcfg(1'(s), 1'b0, clock_ctl_pkg::FN_RMOD));
			locked <= 1'b0;
			watch(8, tm, ta, rl);
			chk1(aux_oe, 1'b1);
			chk1(aux_out, s == 0);
			@(posedge core_clk);
			locked <= 1'b1;
			watch(8, tm, ta, rl);
			chk1(aux_oe, s == 0);
			if (s == 0) chk1(aux_out, 1'b0);
		end
	endtask : t_lock
	// reference loss: relock pulse, unlock indication frozen until it returns
	task automatic t_ref_loss();
		int tm, ta, rl;
		wr(clock_ctl_pkg::REG_GLOBAL, gcfg(1'b0, 1'b0, clock_ctl_pkg::FN_RMOD));
		run <= 3'b110;
		watch(2100, tm, ta, rl);
		chkn(rl, 1, 1);
		@(posedge core_clk);
		locked <= 1'b0;
		watch(8, tm, ta, rl);
		chk1(aux_out, 1'b0);
		@(posedge core_clk);
		run <= 3'b111;
		watch(16, tm, ta, rl);
		chk1(aux_out, 1'b1);
		@(posedge core_clk);
		locked <= 1'b1;
	endtask : t_ref_loss
	// fraction word: ratio as 28.20, scaled up by the reference divider
	task automatic t_fracn();
		logic [31:0] g;
		int tm, ta, rl;
		for (int f = 0; f < 2; f++)
		begin
			for (int v = 0; v < 3; v++)
			begin
				g = gcfg(1'b0, 1'b0, clock_ctl_pkg::FN_RMOD);
				g[clock_ctl_pkg::G_FORMAT] = 1'(f);
				g[clock_ctl_pkg::G_DIV_LO +: 2] = 2'(v);
				wr(clock_ctl_pkg::REG_GLOBAL, g);
				watch(4, tm, ta, rl);
				chk48(fracn, 48'(rat(0)) << ((f == 0 ? 8 : 0) + 2 - v));
			end
		end
	endtask : t_fracn
	// mid-run reset as a field part: main clock held until three mode changes
	task automatic t_field();
		logic [31:0] d;
		int tm, ta, rl;
		@(posedge core_clk);
		rst <= 1'b1;
		strap <= 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		watch(16, tm, ta, rl);
		watch(32, tm, ta, rl);
		chkn(tm, 0, 0);
		for (int n = 1; n <= 3; n++)
		begin
			rd(clock_ctl_pkg::REG_STATUS, d);
			chk1(d[3], 1'b0);
			pins(n % 2, 1'b0);
			watch(8, tm, ta, rl);
		end
		rd(clock_ctl_pkg::REG_STATUS, d);
		chk1(d[3], 1'b1);
		watch(8, tm, ta, rl);
		watch(64, tm, ta, rl);
		chkn(tm, 8, 64);
	endtask : t_field
	// main sequence; inputs start static, reset held 12 cycles
	initial
	begin
		mismatches = 0;
		num_checks = 0;
		rst = 1'b1;
		{m_lo, m_hi, sp, reg_wr, reg_rd} = 5'h00;
		locked = 1'b1;
		strap = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0000_0000;
		run = 3'b111;
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		t_reset_values();
		repeat (10) @(posedge core_clk);
		t_ratio();
		t_disable();
		t_gate();
		t_aux();
		t_lock();
		t_ref_loss();
		t_fracn();
		t_field();
		end_sim();
	end
	// hang guard
	initial
	begin
		#900000;
		mismatches++;
		end_sim();
	end
endmodule : clock_mode_output_control_bench
`default_nettype wire
